/* File: dv/remote_station.sv */
`timescale 1ns/1ns
`default_nettype none
// -----------------------------
// Far end of the twisted pair
// -----------------------------
module remote_station
#(
	parameter int GAP_NS = 20000
)
(
	input wire logic pulse_en_in,
	input wire logic data_en_in,
	input wire logic data_bit_in,
	input wire logic col_en_in,
	output logic line_out,
	output logic coax_col_out
);
	int gap = 0; // Quiet time since the last burst
	int nbit = 0; // Bits sent in the current frame
	logic d; // Bit being coded
	// Frames open with an alternating preamble so the receiver can find mid-bit edges
	always
	begin
		if (data_en_in)
		begin
			d = (nbit < 16) ? nbit[0] : data_bit_in;
			line_out = ~d;
			#50;
			line_out = d;
			#50;
			nbit++;
			gap = 0;
		end
		else
		begin
			// Quiet line rests low; short pulses keep the link alive
			line_out = 1'b0;
			nbit = 0;
			#100;
			gap += 100;
			if (pulse_en_in && gap >= GAP_NS)
			begin
				line_out = 1'b1;
				#100;
				gap = 0;
			end
		end
	end
	// Collision report of a coax transceiver is a free-running square wave
	always #40 coax_col_out = col_en_in ? ~coax_col_out : 1'b0;
endmodule
`default_nettype wire

/* File: dv/tb.sv */
`timescale 1ns/1ns
`default_nettype none
module tb
	import phy_link_pkg::*;
;
	// -----------------------------
	// Signals
	// -----------------------------
	localparam int MSB = 20; // Scaled bit times per millisecond keeps the run short
	logic clk_sys_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic tx_en_n, tx_d, tp_mode, lt_dis, ext_cab, sel_n, rnd_on;
	logic ext_rxd, ext_rxc, ext_crs_n, ext_col_n;
	logic pulse_en, data_en, data_bit, col_en, invert_r;
	logic rnd_d = 1'b0; // Random payload, switched in while rnd_on
	wire logic peer_line, peer_col;
	wire logic [STAT_W-1:0] stat;
	wire logic rxd, rxc, crs_n, col_n, tclk, tpx, tpp, aui, etx_en_n, etx_d;
	wire logic [14:0] obs; // Every watched output in one vector
	int seed = 75546;
	int mismatches = 0;
	int compares = 0;
	int v;
	int i;
	logic [4:0] exp_q[$]; // Notes: output index and expected level
	logic [4:0] note;
	event obs_ev;
	string nm[15] = '{"rx_data", "rx_clock", "carrier_n", "collision_n", "tp_tx",
		"ext_tx_en_n", "ext_tx_data", "link_ok", "jabber", "pol_rev", "tx_clock",
		"aui_tx", "tp_predistort", "col_status", "ext_cable"};
	assign obs = {stat[STAT_EXT_CABLE], stat[STAT_COLLISION], tpp, aui, tclk,
		stat[STAT_POL_REV], stat[STAT_JABBER], stat[STAT_LINK_OK], etx_d,
		etx_en_n, tpx, col_n, crs_n, rxc, rxd};
	always #5 clk_sys_in = ~clk_sys_in;
	// Random payload, used while a runaway transmit is wanted
	always @(posedge clk_sys_in)
		rnd_d <= 1'($random(seed));

	ten_base_t_phy_link_control #(.MS_BITS(MSB), .SQE_WAIT_BITS(8)) dut (
		.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .transmit_enable_n_in(tx_en_n),
		.tx_data_in(rnd_on ? rnd_d : tx_d), .tx_clock_out(tclk), .rx_data_out(rxd),
		.recovered_rx_clock_out(rxc), .carrier_sense_n_out(crs_n),
		.collision_indicator_n_out(col_n), .tp_mode_in(tp_mode),
		.link_test_disable_in(lt_dis), .extended_cable_in(ext_cab),
		.external_codec_select_n_in(sel_n), .rx_line_in(peer_line ^ invert_r),
		.coax_collision_in(peer_col), .tp_tx_out(tpx), .tp_tx_predistort_out(tpp),
		.aui_tx_out(aui), .ext_tx_enable_n_out(etx_en_n), .ext_tx_data_out(etx_d),
		.ext_rx_data_in(ext_rxd), .ext_rx_clock_in(ext_rxc),
		.ext_carrier_n_in(ext_crs_n), .ext_collision_n_in(ext_col_n),
		.phy_status_register_out(stat));

	remote_station #(.GAP_NS(10 * MSB * BIT_NS)) peer (
		.pulse_en_in(pulse_en), .data_en_in(data_en), .data_bit_in(data_bit),
		.col_en_in(col_en), .line_out(peer_line), .coax_col_out(peer_col));

	// -----------------------------
	// Scoreboard
	// -----------------------------
	task automatic compare_bit(input logic [3:0] idx, input logic val);
		compares++;
		if (obs[idx] !== val)
		begin
			mismatches++;
			$display("mismatch %s expected %b seen %b", nm[idx], val, obs[idx]);
		end
	endtask
	// Watcher drains every queued note, oldest first, whenever a result is presented
	always @(obs_ev)
		while (exp_q.size() > 0)
		begin
			note = exp_q.pop_front();
			compare_bit(note[4:1], note[0]);
		end
	task automatic check(input int idx, input logic val);
		exp_q.push_back({4'(idx), val});
		->obs_ev;
	endtask
	task automatic give_verdict;
		#1;
		$display("comparisons %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic done(input string s);
		$display("test %s finished", s);
	endtask
	// Bounded wait on settled outputs; running out ends the run
	task automatic wait_for(input int idx, input logic val, input int lim);
		int n;
		n = 0;
		do
		begin
			@(negedge clk_sys_in);
			n++;
		end
		while (obs[idx] !== val && n < lim);
		if (obs[idx] !== val)
		begin
			$display("mismatch wait %s expected %b seen %b", nm[idx], val, obs[idx]);
			mismatches++;
			give_verdict();
		end
		else
			check(idx, val);
	endtask
	// Lands on the first cycle of a bit period
	task automatic sync_bit;
		wait_for(10, 1'b1, 20);
		wait_for(10, 1'b0, 20);
	endtask
	// Each bit is taken at the period's last cycle; halves sampled mid-way
	task automatic send_frame(input int n, input int ln);
		logic [15:0] d;
		int c;
		d = 16'($random(seed));
		sync_bit();
		for (c = 0; c < 10 * n + 18; c++)
		begin
			@(posedge clk_sys_in);
			if (c % 10 == 0 && c < 10 * n)
			begin
				tx_en_n <= 1'b0;
				tx_d <= d[c / 10];
			end
			if (c == 10 * n)
				tx_en_n <= 1'b1;
			@(negedge clk_sys_in);
			if (c >= 12 && (c - 12) % 10 == 0 && (c - 12) / 10 < n)
			begin
				check(ln, ~d[(c - 12) / 10]);
				if (ln == 4)
					check(12, d[(c - 12) / 10]);
			end
			if (c >= 17 && (c - 17) % 10 == 0 && (c - 17) / 10 < n)
			begin
				check(ln, d[(c - 17) / 10]);
				if (ln == 4)
					check(12, ~d[(c - 17) / 10]);
			end
			if (c == 12 && ln == 4)
				check(2, 1'b0);
		end
	endtask

	// -----------------------------
	// Main sequence
	// -----------------------------
	initial
	begin
		{tx_en_n, sel_n, ext_crs_n, ext_col_n, tp_mode} = 5'h1f;
		{tx_d, lt_dis, ext_rxd, ext_rxc, rnd_on} = 5'h00;
		{pulse_en, data_en, data_bit, col_en, invert_r} = 5'h00;
		ext_cab = 1'($random(seed));
		repeat (5) @(posedge clk_sys_in);
		rst_n_in <= 1'b1;
		repeat (3) @(negedge clk_sys_in);
		check(2, 1'b1);
		check(3, 1'b1);
		check(7, 1'b0);
		check(14, ext_cab);
		done("reset");
		sync_bit();
		repeat (2) @(negedge clk_sys_in);
		check(1, 1'b0);
		repeat (5) @(negedge clk_sys_in);
		check(1, 1'b1);
		done("idle clock");
		@(posedge clk_sys_in);
		pulse_en <= 1'b1;
		wait_for(7, 1'b1, 6000);
		done("link up");
		send_frame(16, 4);
		wait_for(3, 1'b0, 200);
		repeat (40) @(negedge clk_sys_in);
		check(3, 1'b0);
		wait_for(3, 1'b1, 120);
		done("frame and quality test");
		@(posedge clk_sys_in);
		data_bit <= 1'b1;
		data_en <= 1'b1;
		wait_for(2, 1'b0, 80);
		repeat (300) @(negedge clk_sys_in);
		check(0, 1'b1);
		@(posedge clk_sys_in);
		data_bit <= 1'b0;
		repeat (60) @(negedge clk_sys_in);
		check(0, 1'b0);
		@(posedge clk_sys_in);
		data_en <= 1'b0;
		wait_for(2, 1'b1, 60);
		done("receive");
		// Both ends talking at once, then the far end stops first
		@(posedge clk_sys_in);
		tx_en_n <= 1'b0;
		data_en <= 1'b1;
		wait_for(3, 1'b0, 100);
		check(13, 1'b1);
		@(posedge clk_sys_in);
		data_en <= 1'b0;
		wait_for(3, 1'b1, 100);
		@(posedge clk_sys_in);
		tx_en_n <= 1'b1;
		done("collision");
		repeat (40) @(negedge clk_sys_in);
		wait_for(4, 1'b1, 3600);
		repeat (15) @(negedge clk_sys_in);
		check(4, 1'b0);
		done("link pulse");
		@(posedge clk_sys_in);
		pulse_en <= 1'b0;
		wait_for(7, 1'b0, 14000);
		@(posedge clk_sys_in);
		lt_dis <= 1'b1;
		send_frame(4, 4);
		done("link loss");
		@(posedge clk_sys_in);
		tp_mode <= 1'b0;
		col_en <= 1'b1;
		wait_for(3, 1'b0, 40);
		@(posedge clk_sys_in);
		col_en <= 1'b0;
		wait_for(3, 1'b1, 60);
		send_frame(4, 11);
		@(posedge clk_sys_in);
		tp_mode <= 1'b1;
		done("coax collision");
		// External codec: every routed signal follows its source
		@(posedge clk_sys_in);
		sel_n <= 1'b0;
		for (v = 0; v < 2; v++)
		begin
			@(posedge clk_sys_in);
			{ext_rxd, ext_rxc, ext_crs_n, ext_col_n, tx_en_n, tx_d} <= {6{v[0]}};
			repeat (6) @(negedge clk_sys_in);
			for (i = 0; i < 7; i++)
				if (i != 4)
					check(i, v[0]);
		end
		@(posedge clk_sys_in);
		sel_n <= 1'b1;
		done("external codec");
		@(posedge clk_sys_in);
		tx_en_n <= 1'b0;
		rnd_on <= 1'b1;
		wait_for(8, 1'b1, 7000);
		check(3, 1'b0);
		@(posedge clk_sys_in);
		tx_en_n <= 1'b1;
		rnd_on <= 1'b0;
		wait_for(8, 1'b0, 53000);
		done("jabber");
		// Crossed pair: the line now rests high
		@(posedge clk_sys_in);
		invert_r <= 1'b1;
		pulse_en <= 1'b1;
		wait_for(9, 1'b1, 5000);
		done("polarity");
		give_verdict();
	end
endmodule
`default_nettype wire

/* File: logic/phy_link_pkg.sv */
package phy_link_pkg;

	// --------------------------------
	// Clock and bit timing
	// --------------------------------
	localparam int CLK_NS = 10; // System clock period
	localparam int BIT_NS = 100; // One bit time
	localparam int CYC_PER_BIT = BIT_NS / CLK_NS;
	localparam int HALF_CYC = CYC_PER_BIT / 2;
	localparam int MS_NS = 1000000;
	localparam int BITS_PER_MS = MS_NS / BIT_NS;

	// --------------------------------
	// Timers
	// --------------------------------
	localparam int JABBER_MS = 32;
	localparam int UNJAB_MS = 256;
	localparam int SQE_DELAY_NS = 1000000; // One ms, inside the 0.6 to 1.6 ms window
	localparam int SQE_DELAY_BITS = SQE_DELAY_NS / BIT_NS;
	localparam int SQE_BITS = 10;
	localparam int LINK_PULSE_MS = 16;
	localparam int LINK_LOSS_MS = 64;
	localparam int TEST_MIN_MS = 4;
	localparam int TEST_MAX_MS = 64;
	localparam int LINK_COUNT = 2;

	// --------------------------------
	// Squelch and line activity
	// --------------------------------
	localparam int SQ_REJECT_NS = 15;
	localparam int SQ_ACCEPT_NS = 30;
	localparam int SQ_ACCEPT_CYC = (SQ_ACCEPT_NS + CLK_NS - 1) / CLK_NS;
	localparam int IDLE_CYC = 2 * CYC_PER_BIT; // Quiet this long means idle
	localparam int LP_MAX_CYC = 2 * CYC_PER_BIT; // Shorter bursts are link pulses
	localparam int MID_GAP_CYC = CYC_PER_BIT * 3 / 4;

	// --------------------------------
	// Status field positions
	// --------------------------------
	localparam int STAT_LINK_OK = 0;
	localparam int STAT_JABBER = 1;
	localparam int STAT_POL_REV = 2;
	localparam int STAT_COLLISION = 3;
	localparam int STAT_EXT_CABLE = 4;
	localparam int STAT_W = 5;

	// --------------------------------
	// Synchroniser bit positions
	// --------------------------------
	localparam int SY_LINE = 0;
	localparam int SY_COAX_COL = 1;
	localparam int SY_EXT_RXD = 2;
	localparam int SY_EXT_RECOVERED_RX_CLOCK = 3;
	localparam int SY_EXT_CRS_N = 4;
	localparam int SY_EXT_COL_N = 5;
	localparam int SY_XSEL_N = 6;
	localparam int SYNC_W = 7;
	localparam logic [SYNC_W-1:0] SYNC_RST = 7'h70; // Active-low inputs rest high

	typedef enum logic {LINK_FAIL, LINK_PASS} link_state_t;

endpackage

/* File: logic/ten_base_t_phy_link_control.sv */
`timescale 1ns/1ns
`default_nettype none
module ten_base_t_phy_link_control
	import phy_link_pkg::*;
#(
	parameter int MS_BITS = BITS_PER_MS,
	parameter int SQE_WAIT_BITS = SQE_DELAY_BITS
)
(
	input wire logic clk_sys_in,
	input wire logic rst_n_in,
	input wire logic transmit_enable_n_in,
	input wire logic tx_data_in,
	output logic tx_clock_out,
	output logic rx_data_out,
	output logic recovered_rx_clock_out,
	output logic carrier_sense_n_out,
	output logic collision_indicator_n_out,
	input wire logic tp_mode_in,
	input wire logic link_test_disable_in,
	input wire logic extended_cable_in,
	input wire logic external_codec_select_n_in,
	input wire logic rx_line_in,
	input wire logic coax_collision_in,
	output logic tp_tx_out,
	output logic tp_tx_predistort_out,
	output logic aui_tx_out,
	output logic ext_tx_enable_n_out,
	output logic ext_tx_data_out,
	input wire logic ext_rx_data_in,
	input wire logic ext_rx_clock_in,
	input wire logic ext_carrier_n_in,
	input wire logic ext_collision_n_in,
	output logic [STAT_W-1:0] phy_status_register_out
);

	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (!rst_n_in);

	// --------------------------------
	// Declarations
	// --------------------------------
	logic [SYNC_W-1:0] sync1_r; // First stage, read only by stage two
	logic [SYNC_W-1:0] sync2_r; // Safe copies of pin inputs
	logic [3:0] cyc_r; // Cycle within bit time
	logic [15:0] msdiv_r; // Bit times within one ms
	logic bit_en;
	logic half;
	logic ms_en;
	logic ext_sel; // External codec owns the MAC signals
	logic tx_req;
	logic tx_allow;
	logic tx_on_r; // Encoder is sending
	logic tx_bit_r; // Bit being encoded
	logic manch;
	logic tx_line;
	logic jabber_r;
	logic [8:0] jab_ms_r;
	logic lp_r; // Outgoing link pulse
	logic [4:0] lp_ms_r;
	logic line_raw;
	logic line_prev_r;
	logic pol_inv_r;
	logic line_pol;
	logic [4:0] wid_r; // Cycles since last line edge
	logic act_r; // Squelch-accepted line activity
	logic [4:0] burst_r;
	logic act_end;
	logic data_act;
	logic lp_rx;
	logic coax_prev_r;
	logic [4:0] cwid_r;
	logic col_now;
	logic loop_ok;
	logic use_loop;
	logic rx_src;
	logic src_prev_r;
	logic [4:0] gap_r; // Cycles since last mid-bit edge
	logic rx_bit_r;
	logic recovered_rx_clock_r;
	logic crs_int;
	logic tx_on_d_r;
	logic sqe_pend_r;
	logic sqe_on_r;
	logic [15:0] sqe_wait_r;
	logic [3:0] sqe_len_r;
	link_state_t st_r;
	logic [6:0] lk_ms_r;
	logic [1:0] lk_cnt_r;

	// --------------------------------
	// Input synchronisers
	// --------------------------------
	// Line, coax and external codec pins pass two flops before any logic looks at them
	always_ff @(posedge clk_sys_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			sync1_r <= SYNC_RST;
			sync2_r <= SYNC_RST;
		end
		else
		begin
			sync1_r <= {external_codec_select_n_in, ext_collision_n_in, ext_carrier_n_in,
				ext_rx_clock_in, ext_rx_data_in, coax_collision_in, rx_line_in};
			sync2_r <= sync1_r;
		end
	end

	assign ext_sel = ~sync2_r[SY_XSEL_N];

	// --------------------------------
	// Bit and millisecond enables
	// --------------------------------
	assign bit_en = (cyc_r == CYC_PER_BIT - 1);
	assign half = (cyc_r < HALF_CYC);
	assign ms_en = bit_en && (msdiv_r == MS_BITS - 1);
	assign tx_clock_out = ~half;

	// Bit clock divider and ms prescaler share one chain
	always_ff @(posedge clk_sys_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			cyc_r <= 4'h0;
			msdiv_r <= 16'h0000;
		end
		else
		begin
			cyc_r <= bit_en ? 4'h0 : cyc_r + 4'h1;
			if (ms_en)
				msdiv_r <= 16'h0000;
			else if (bit_en)
				msdiv_r <= msdiv_r + 16'h0001;
		end
	end

	// --------------------------------
	// Transmit path
	// --------------------------------
	assign tx_req = ~transmit_enable_n_in & ~ext_sel;
	// Jabber and a failed link only gate the twisted pair side
	assign tx_allow = ~tp_mode_in | (~jabber_r & (st_r == LINK_PASS | link_test_disable_in));
	assign manch = half ? ~tx_bit_r : tx_bit_r;
	assign tx_line = tx_on_r & manch;

	// Frames start on a bit boundary; a block cuts them at once
	always_ff @(posedge clk_sys_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			tx_on_r <= 1'b0;
			tx_bit_r <= 1'b0;
		end
		else if (!tx_allow)
			tx_on_r <= 1'b0;
		else if (bit_en)
		begin
			tx_on_r <= tx_req;
			tx_bit_r <= tx_data_in;
		end
	end

	// Line drivers are registered to keep glitches off the pins
	always_ff @(posedge clk_sys_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			tp_tx_out <= 1'b0;
			tp_tx_predistort_out <= 1'b0;
			aui_tx_out <= 1'b0;
			ext_tx_enable_n_out <= 1'b1;
			ext_tx_data_out <= 1'b0;
		end
		else
		begin
			tp_tx_out <= tp_mode_in & (tx_on_r ? manch : lp_r);
			tp_tx_predistort_out <= tp_mode_in & tx_on_r & ~manch;
			aui_tx_out <= ~tp_mode_in & tx_line;
			ext_tx_enable_n_out <= ~(ext_sel & ~transmit_enable_n_in);
			ext_tx_data_out <= ext_sel & tx_data_in;
		end
	end

	AST_MANCH: assert property (tp_mode_in && tx_on_r && cyc_r == 4'h0 ##5 tx_on_r
		|-> ##1 tp_tx_out != $past(tp_tx_out, 5)) else $error("no mid-bit transition");
	AST_EXT_ROUTE: assert property (ext_sel && !transmit_enable_n_in
		|=> !ext_tx_enable_n_out && !tx_on_r) else $error("external codec not routed");

	// --------------------------------
	// Jabber
	// --------------------------------
	// Counts ms of transmit, then ms of idle before unjabbing
	always_ff @(posedge clk_sys_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			jabber_r <= 1'b0;
			jab_ms_r <= 9'h000;
		end
		else if (!tp_mode_in)
		begin
			jabber_r <= 1'b0; // Coax transceiver jabbers itself
			jab_ms_r <= 9'h000;
		end
		else if (!jabber_r)
		begin
			if (!tx_on_r)
				jab_ms_r <= 9'h000;
			else if (ms_en && jab_ms_r == JABBER_MS - 1)
			begin
				jabber_r <= 1'b1;
				jab_ms_r <= 9'h000;
			end
			else if (ms_en)
				jab_ms_r <= jab_ms_r + 9'h001;
		end
		else if (tx_req)
			jab_ms_r <= 9'h000; // Any transmit attempt restarts idle wait
		else if (ms_en && jab_ms_r == UNJAB_MS)
			jabber_r <= 1'b0;
		else if (ms_en)
			jab_ms_r <= jab_ms_r + 9'h001;
	end

	AST_JABBER_CUTS: assert property (jabber_r |=> !tx_on_r)
		else $error("transmit during jabber");
	AST_UNJAB_IDLE: assert property ($fell(jabber_r) && tp_mode_in
		|-> $past(jab_ms_r) == UNJAB_MS) else $error("unjab too early");

	// --------------------------------
	// Link pulse generator
	// --------------------------------
	// Timer restarts after every frame or pulse; pulse lasts one bit
	always_ff @(posedge clk_sys_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			lp_r <= 1'b0;
			lp_ms_r <= 5'h00;
		end
		else
		begin
			if (lp_r && bit_en)
				lp_r <= 1'b0;
			else if (ms_en && tp_mode_in && !tx_on_r && lp_ms_r == LINK_PULSE_MS - 1)
				lp_r <= 1'b1;
			if (tx_on_r || lp_r || !tp_mode_in)
				lp_ms_r <= 5'h00;
			else if (ms_en && lp_ms_r == LINK_PULSE_MS - 1)
				lp_ms_r <= 5'h00; // Pulse is due now; never let the count pass its limit
			else if (ms_en)
				lp_ms_r <= lp_ms_r + 5'h01;
		end
	end

	AST_LP_PERIOD: assert property (lp_ms_r < LINK_PULSE_MS)
		else $error("link pulse overdue");

	// --------------------------------
	// Receive squelch and polarity
	// --------------------------------
	assign line_raw = sync2_r[SY_LINE];
	assign line_pol = line_raw ^ pol_inv_r;
	assign act_end = act_r && !(line_raw ^ line_prev_r) && wid_r == IDLE_CYC - 1;
	assign data_act = act_r && burst_r == LP_MAX_CYC;
	assign lp_rx = act_end && burst_r != LP_MAX_CYC;

	// A pulse counts only if its width, edge to edge, passes squelch
	always_ff @(posedge clk_sys_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			line_prev_r <= 1'b0;
			wid_r <= 5'(IDLE_CYC);
			act_r <= 1'b0;
			burst_r <= 5'h00;
			pol_inv_r <= 1'b0;
		end
		else
		begin
			line_prev_r <= line_raw;
			if (line_raw ^ line_prev_r)
			begin
				wid_r <= 5'h00;
				if (wid_r >= SQ_ACCEPT_CYC - 1 && wid_r != IDLE_CYC)
					act_r <= 1'b1;
			end
			else if (wid_r != IDLE_CYC)
				wid_r <= wid_r + 5'h01;
			if (act_end)
				act_r <= 1'b0;
			if (!act_r)
				burst_r <= 5'h00;
			else if (burst_r != LP_MAX_CYC)
				burst_r <= burst_r + 5'h01;
			// Line should rest low; resting high means crossed pair
			if (act_end)
				pol_inv_r <= tp_mode_in & line_raw;
		end
	end

	// --------------------------------
	// Coax collision presence
	// --------------------------------
	// Any toggling in the last two bit times means collision
	always_ff @(posedge clk_sys_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			coax_prev_r <= 1'b0;
			cwid_r <= 5'(IDLE_CYC);
		end
		else
		begin
			coax_prev_r <= sync2_r[SY_COAX_COL];
			if (sync2_r[SY_COAX_COL] ^ coax_prev_r)
				cwid_r <= 5'h00;
			else if (cwid_r != IDLE_CYC)
				cwid_r <= cwid_r + 5'h01;
		end
	end

	// --------------------------------
	// Collision and loopback select
	// --------------------------------
	assign col_now = tp_mode_in ? (tx_on_r & act_r) : (cwid_r != IDLE_CYC);
	assign loop_ok = tp_mode_in & ~jabber_r & (st_r == LINK_PASS | link_test_disable_in);
	assign use_loop = loop_ok & ~act_r;
	assign rx_src = tp_mode_in ? (use_loop ? tx_line : line_pol) : line_raw;

	AST_LOOP_BACK: assert property ($fell(act_r) && loop_ok |-> use_loop)
		else $error("loopback not restored");
	AST_NET_IN_COL: assert property (tp_mode_in && act_r |-> rx_src == line_pol)
		else $error("receiver not on network");

	// --------------------------------
	// Manchester decoder
	// --------------------------------
	// Edges near mid-bit carry data; boundary edges are skipped
	always_ff @(posedge clk_sys_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			src_prev_r <= 1'b0;
			gap_r <= 5'(IDLE_CYC);
			rx_bit_r <= 1'b0;
			recovered_rx_clock_r <= 1'b0;
		end
		else
		begin
			src_prev_r <= rx_src;
			if ((rx_src ^ src_prev_r) && gap_r >= MID_GAP_CYC - 1)
			begin
				gap_r <= 5'h00;
				rx_bit_r <= rx_src;
				recovered_rx_clock_r <= 1'b1;
			end
			else
			begin
				if (gap_r != IDLE_CYC)
					gap_r <= gap_r + 5'h01;
				if (gap_r == HALF_CYC - 1)
					recovered_rx_clock_r <= 1'b0;
			end
		end
	end

	// --------------------------------
	// MAC side outputs
	// --------------------------------
	assign crs_int = data_act | (use_loop & tx_on_r);

	// External codec pins take over every MAC-facing output except tx_clock_out
	always_ff @(posedge clk_sys_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			rx_data_out <= 1'b0;
			recovered_rx_clock_out <= 1'b0;
			carrier_sense_n_out <= 1'b1;
			collision_indicator_n_out <= 1'b1;
		end
		else if (ext_sel)
		begin
			rx_data_out <= sync2_r[SY_EXT_RXD];
			recovered_rx_clock_out <= sync2_r[SY_EXT_RECOVERED_RX_CLOCK];
			carrier_sense_n_out <= sync2_r[SY_EXT_CRS_N];
			collision_indicator_n_out <= sync2_r[SY_EXT_COL_N];
		end
		else
		begin
			rx_data_out <= rx_bit_r;
			// Idle receive clock tracks transmit clock so the MAC never stalls
			recovered_rx_clock_out <= (gap_r != IDLE_CYC) ? recovered_rx_clock_r : ~half;
			carrier_sense_n_out <= ~crs_int;
			collision_indicator_n_out <= ~(col_now | (tp_mode_in & jabber_r) | sqe_on_r);
		end
	end

	AST_COL_TP: assert property (!ext_sel && tp_mode_in && tx_on_r && act_r
		|=> !collision_indicator_n_out) else $error("collision not shown");
	AST_COL_RELEASE: assert property ($fell(col_now) && !ext_sel |-> ##[1:90]
		(collision_indicator_n_out || col_now || sqe_on_r || jabber_r))
		else $error("collision held too long");
	AST_JAB_COL: assert property (!ext_sel && tp_mode_in && jabber_r
		|=> !collision_indicator_n_out) else $error("jabber without collision");

	// --------------------------------
	// SQE test
	// --------------------------------
	// Delay counted in bit times from the frame's final bit
	always_ff @(posedge clk_sys_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			tx_on_d_r <= 1'b0;
			sqe_pend_r <= 1'b0;
			sqe_on_r <= 1'b0;
			sqe_wait_r <= 16'h0000;
			sqe_len_r <= 4'h0;
		end
		else
		begin
			tx_on_d_r <= tx_on_r;
			if (tx_on_d_r && !tx_on_r && tp_mode_in && !jabber_r)
			begin
				sqe_pend_r <= 1'b1;
				sqe_wait_r <= 16'h0000;
			end
			else if (sqe_pend_r && bit_en)
			begin
				if (sqe_wait_r == SQE_WAIT_BITS - 1)
				begin
					sqe_pend_r <= 1'b0;
					sqe_on_r <= 1'b1;
					sqe_len_r <= 4'h0;
				end
				else
					sqe_wait_r <= sqe_wait_r + 16'h0001;
			end
			if (sqe_on_r && bit_en)
			begin
				if (sqe_len_r == SQE_BITS - 1)
					sqe_on_r <= 1'b0;
				else
					sqe_len_r <= sqe_len_r + 4'h1;
			end
		end
	end

	AST_SQE_LEN: assert property (sqe_on_r |-> sqe_len_r < SQE_BITS)
		else $error("SQE pulse too long");
	AST_SQE_DELAY: assert property ($rose(sqe_on_r) |-> $past(sqe_wait_r) == SQE_WAIT_BITS - 1)
		else $error("SQE delay wrong");

	// --------------------------------
	// Link integrity state machine
	// --------------------------------
	// Fail ends on two pulses spaced at least min and within max, or on one data burst
	always_ff @(posedge clk_sys_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			st_r <= LINK_FAIL;
			lk_ms_r <= 7'h00;
			lk_cnt_r <= 2'h0;
		end
		else if (!tp_mode_in)
		begin
			st_r <= LINK_PASS; // No link test on coax
			lk_ms_r <= 7'h00;
			lk_cnt_r <= 2'h0;
		end
		else
		begin
			unique case (st_r)
				LINK_PASS:
				begin
					if (lp_rx || data_act)
						lk_ms_r <= 7'h00;
					else if (ms_en && lk_ms_r == LINK_LOSS_MS - 1)
					begin
						st_r <= LINK_FAIL;
						lk_ms_r <= 7'h00;
						lk_cnt_r <= 2'h0;
					end
					else if (ms_en)
						lk_ms_r <= lk_ms_r + 7'h01;
				end
				LINK_FAIL:
				begin
					if (data_act)
					begin
						st_r <= LINK_PASS;
						lk_ms_r <= 7'h00;
					end
					else if (lp_rx && lk_cnt_r != 2'h0 && lk_ms_r >= TEST_MIN_MS)
					begin
						lk_ms_r <= 7'h00;
						lk_cnt_r <= lk_cnt_r + 2'h1;
						if (lk_cnt_r + 2'h1 == LINK_COUNT)
							st_r <= LINK_PASS;
					end
					else if (lp_rx)
					begin
						lk_ms_r <= 7'h00; // First or too-early pulse restarts
						lk_cnt_r <= 2'h1;
					end
					else if (ms_en && lk_cnt_r != 2'h0)
					begin
						if (lk_ms_r == TEST_MAX_MS - 1)
						begin
							lk_cnt_r <= 2'h0;
							lk_ms_r <= 7'h00;
						end
						else
							lk_ms_r <= lk_ms_r + 7'h01;
					end
				end
			endcase
		end
	end

	AST_LINK_FAIL_TX: assert property (tp_mode_in && st_r == LINK_FAIL && !link_test_disable_in
		|-> !use_loop ##1 !tx_on_r) else $error("transmit with link down");
	AST_LINK_DISABLE: assert property (link_test_disable_in && tp_mode_in && !jabber_r && !ext_sel
		&& !transmit_enable_n_in && bit_en |=> tx_on_r) else $error("link test not bypassed");

	// --------------------------------
	// Status output
	// --------------------------------
	always_ff @(posedge clk_sys_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			phy_status_register_out <= 5'h00;
		else
		begin
			phy_status_register_out[STAT_LINK_OK] <= (st_r == LINK_PASS);
			phy_status_register_out[STAT_JABBER] <= jabber_r;
			phy_status_register_out[STAT_POL_REV] <= pol_inv_r;
			phy_status_register_out[STAT_COLLISION] <= col_now;
			phy_status_register_out[STAT_EXT_CABLE] <= extended_cable_in;
		end
	end

	AST_STATUS: assert property (phy_status_register_out[STAT_LINK_OK]
		|-> $past(st_r) == LINK_PASS) else $error("status disagrees with link");

	COV_JABBER: cover property ($rose(jabber_r));
	COV_SQE: cover property ($rose(sqe_on_r));
	COV_LINK_UP: cover property (st_r == LINK_FAIL ##1 st_r == LINK_PASS);
	COV_COLLISION: cover property (tx_on_r && act_r);

endmodule
`default_nettype wire
